//--- sss_cfg.svh
// Purpose: constants for the supply status signaling block
// Assumes: 40 MHz clock, counts derived from times in their own unit
// Notes: header holds definitions only
`ifndef SSS_CFG_SVH
`define SSS_CFG_SVH

`define SSS_CLK_HZ 40000000
// times and inlet warning temperature as printed
`define SSS_DWELL_MS 75
`define SSS_OFF_MIN_MS 1000
`define SSS_PGOOD_ON_MS 100
`define SSS_RMS_EVAL_MS 100
`define SSS_VIN_DELAY_MS 1700
`define SSS_PGOOD_OFF_MS 5
`define SSS_ALERT_MS 2
`define SSS_INLET_WARN_C 60
// derived cycle counts (least times round up)
`define SSS_MS_CYC(ms) ((((ms) * 64'd40000000) + 64'd999) / 64'd1000)
`define SSS_DWELL_CYC `SSS_MS_CYC(`SSS_DWELL_MS)
`define SSS_OFF_MIN_CYC `SSS_MS_CYC(`SSS_OFF_MIN_MS)
`define SSS_PGOOD_ON_CYC `SSS_MS_CYC(`SSS_PGOOD_ON_MS)
`define SSS_RMS_EVAL_CYC `SSS_MS_CYC(`SSS_RMS_EVAL_MS)
// debounce length in cycles
`define SSS_DEB_LEN 4
// register byte offsets
`define SSS_REG_CTRL 12'h000
`define SSS_REG_STATUS 12'h004
`define SSS_REG_TEMP 12'h008
`define SSS_REG_VRMS 12'h00c
// status bit positions
`define SSS_ST_PGOOD 0
`define SSS_ST_VIN_OK 1
`define SSS_ST_ALERT 2
`define SSS_ST_MAIN_EN 3
`define SSS_ST_WARN_TEMP 4
`define SSS_ST_SHUT 5
`define SSS_ST_PDWARN 6
`define SSS_ST_FAN_MAX 7
`define SSS_ST_STBY 8
// control and temperature reset values
`define SSS_CTRL_RST 32'h0000_0000
`define SSS_TEMP_RST 8'h00

`endif

//--- sss_pkg.sv
// Purpose: types for the supply status signaling block
// Assumes: AXI4-Lite register bus with 32-bit data
// Notes: constants live in sss_cfg.svh
package sss_pkg;

	typedef enum logic [1:0] {
		SSS_RESP_OKAY = 2'b00,
		SSS_RESP_SLVERR = 2'b10
	} sss_resp_t;

	typedef struct packed {
		logic [11:0] addr;
		logic [2:0] prot;
	} sss_ax_t;

	typedef struct packed {
		logic [31:0] data;
		logic [3:0] strb;
	} sss_w_t;

	// analog monitor conditions, already compared against limits
	typedef struct packed {
		logic vin_above_min;
		logic vin_below_off;
		logic vin_ovp;
		logic rails_in_reg;
		logic current_limit;
		logic sense_short;
		logic stby_in_reg;
		logic shut_event;
		logic warn_event;
	} sss_mon_t;

	typedef enum {
		SSS_MAIN_OFF,
		SSS_MAIN_RAMP,
		SSS_MAIN_ON,
		SSS_MAIN_HOLD
	} sss_main_t;

	typedef enum {
		SSS_VIN_EVAL,
		SSS_VIN_GOOD,
		SSS_VIN_DWELL,
		SSS_VIN_AVG
	} sss_vin_t;

endpackage : sss_pkg

//--- sss_status.sv
// Purpose: status and control signaling of a front-end supply
// Assumes: monitor inputs synchronous to clk; nrst synchronous, active low
// Notes: open-drain pins are given as output plus output enable
//
// Summary of operation
// [RULE_01] active-high pull-out disconnects main output at once
// [RULE_02] standby output enabled regardless of pull-out
// [RULE_03] sense short circuit shuts supply down
// [RULE_04] outputs good high only when all regulated
// [RULE_05] outputs good low on droop or input loss
// [RULE_06] current limit holds off outputs good timer
// [RULE_07] outputs good drives only low, wire-OR safe
// [RULE_08] fault alert low on shutdown or warning
// [RULE_09] alert asserted together with steady amber state
// [RULE_10] inlet warning at 60 degrees Celsius
// [RULE_11] inlet warning clears inside operating range
// [RULE_12] fan at maximum before overtemp bit set
// [RULE_13] input good high when input meets minimum
// [RULE_14] input good low on input overvoltage
// [RULE_15] input evaluated within 100 ms after standby
// [RULE_16] brownout and dropout raise power-down warning
// [RULE_17] input good low below turn-off threshold
// [RULE_18] reassert only from moving-average over dwell
// [RULE_19] input good held low 75 to 120 ms
// [RULE_20] input good to main transition within 1700 ms
// [RULE_21] presence pulled low while seated
// [RULE_22] main enabled while request low, else off
// [RULE_23] outputs off one second after good drops
// [RULE_24] outputs good drops within 5 ms of request
// [RULE_25] alert within 2 ms of input loss
// [RULE_26] pull-out and request inputs synced, debounced
`timescale 1ns/10ps
`include "sss_cfg.svh"

module sss_status (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// axi4-lite write address
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire sss_pkg::sss_ax_t s_axi_aw,
	// axi4-lite write data
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire sss_pkg::sss_w_t s_axi_w,
	// axi4-lite write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output sss_pkg::sss_resp_t s_axi_bresp,
	// axi4-lite read address
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire sss_pkg::sss_ax_t s_axi_ar,
	// axi4-lite read data
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output sss_pkg::sss_resp_t s_axi_rresp,
	// system pins
	input wire logic pull_out_disconnect_in,
	input wire logic main_on_request_n,
	output logic outputs_good_o,
	output logic outputs_good_oe,
	output logic fault_alert_n_o,
	output logic fault_alert_n_oe,
	output logic input_good_o,
	output logic input_good_oe,
	output logic presence_n_o,
	output logic presence_n_oe,
	// monitor side
	input wire sss_pkg::sss_mon_t mon,
	input wire logic [11:0] vrms_sample,
	input wire logic fan_at_max,
	// power stage control
	output logic main_enable,
	output logic standby_enable,
	output logic fan_max_req,
	output logic power_down_warn,
	output logic amber_steady
);
	import sss_pkg::*;

	// ----------------------------------------
	// input synchronisers and debounce
	// ----------------------------------------
	logic [1:0] kill_sync_q;
	logic [1:0] req_sync_q;
	logic [`SSS_DEB_LEN-1:0] kill_hist_q;
	logic [`SSS_DEB_LEN-1:0] req_hist_q;
	logic kill_q;
	logic req_n_q;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			kill_sync_q <= 2'h0;
			req_sync_q <= 2'h3;
			kill_hist_q <= '0;
			req_hist_q <= '1;
			kill_q <= 1'b0;
			req_n_q <= 1'b1;
		end else begin
			kill_sync_q <= {kill_sync_q[0], pull_out_disconnect_in}; // [RULE_26]
			req_sync_q <= {req_sync_q[0], main_on_request_n}; // [RULE_26]
			kill_hist_q <= {kill_hist_q[`SSS_DEB_LEN-2:0], kill_sync_q[1]};
			req_hist_q <= {req_hist_q[`SSS_DEB_LEN-2:0], req_sync_q[1]};
			if (&kill_hist_q)
				kill_q <= 1'b1; // [RULE_26]
			else if (~|kill_hist_q)
				kill_q <= 1'b0;
			if (&req_hist_q)
				req_n_q <= 1'b1; // [RULE_26]
			else if (~|req_hist_q)
				req_n_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// register bus
	// ----------------------------------------
	logic [31:0] ctrl_q;
	logic [7:0] temp_q;
	logic [11:0] aw_addr_q;
	logic aw_have_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic w_have_q;
	logic [31:0] status_w;
	logic shut_q;
	logic temp_warn_q;
	logic sw_kill;
	logic [11:0] vrms_avg_q;

	function automatic logic reg_hit(input logic [11:0] a);
		reg_hit = (a == `SSS_REG_CTRL) || (a == `SSS_REG_STATUS) ||
			(a == `SSS_REG_TEMP) || (a == `SSS_REG_VRMS);
	endfunction : reg_hit

	assign sw_kill = ctrl_q[0];

	always_ff @(posedge clk) begin
		if (!nrst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= 12'h000;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= SSS_RESP_OKAY;
			ctrl_q <= `SSS_CTRL_RST;
			temp_q <= `SSS_TEMP_RST;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr_q <= s_axi_aw.addr;
				aw_have_q <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_q <= s_axi_w.data;
				w_strb_q <= s_axi_w.strb;
				w_have_q <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (aw_have_q && w_have_q && !s_axi_bvalid) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= reg_hit(aw_addr_q) ? SSS_RESP_OKAY : SSS_RESP_SLVERR;
				if (aw_addr_q == `SSS_REG_CTRL) begin
					for (int i = 0; i < 4; i++) begin
						if (w_strb_q[i])
							ctrl_q[i*8 +: 8] <= w_data_q[i*8 +: 8];
					end
				end
				if (aw_addr_q == `SSS_REG_TEMP && w_strb_q[0])
					temp_q <= w_data_q[7:0];
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= SSS_RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= reg_hit(s_axi_ar.addr) ? SSS_RESP_OKAY : SSS_RESP_SLVERR;
				case (s_axi_ar.addr)
					`SSS_REG_CTRL: s_axi_rdata <= ctrl_q;
					`SSS_REG_STATUS: s_axi_rdata <= status_w;
					`SSS_REG_TEMP: s_axi_rdata <= {24'h00_0000, temp_q};
					`SSS_REG_VRMS: s_axi_rdata <= {20'h0_0000, vrms_avg_q};
					default: s_axi_rdata <= 32'h0000_0000;
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// temperature warning and fan
	// ----------------------------------------
	logic fan_max_q;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			fan_max_q <= 1'b0;
			temp_warn_q <= 1'b0;
		end else begin
			fan_max_q <= (temp_q >= 8'(`SSS_INLET_WARN_C)); // [RULE_12]
			if (temp_q >= 8'(`SSS_INLET_WARN_C) && fan_max_q && fan_at_max)
				temp_warn_q <= 1'b1; // [RULE_10] [RULE_12]
			else if (temp_q < 8'(`SSS_INLET_WARN_C))
				temp_warn_q <= 1'b0; // [RULE_11]
		end
	end

	// ----------------------------------------
	// input-good evaluation and dwell
	// ----------------------------------------
	sss_vin_t vin_st_q;
	logic [31:0] vin_cnt_q;
	logic [33:0] vin_acc_q;
	logic vin_good_q;
	logic pd_warn_q;
	logic vin_loss;

	assign vin_loss = mon.vin_below_off || mon.vin_ovp;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			vin_st_q <= SSS_VIN_EVAL;
			vin_cnt_q <= 32'h0000_0000;
			vin_acc_q <= 34'h0_0000_0000;
			vin_good_q <= 1'b0;
			pd_warn_q <= 1'b0;
			vrms_avg_q <= 12'h000;
		end else begin
			case (vin_st_q)
				SSS_VIN_EVAL: begin
					vin_good_q <= 1'b0;
					if (!mon.stby_in_reg)
						vin_cnt_q <= 32'h0000_0000;
					else if (mon.vin_above_min && !vin_loss) begin
						vin_good_q <= 1'b1; // [RULE_13] [RULE_15]
						pd_warn_q <= 1'b0;
						vin_st_q <= SSS_VIN_GOOD;
					end else if (vin_cnt_q < 32'(`SSS_RMS_EVAL_CYC))
						vin_cnt_q <= vin_cnt_q + 32'h1; // [RULE_15]
				end
				SSS_VIN_GOOD: begin
					if (vin_loss || !mon.vin_above_min) begin
						vin_good_q <= 1'b0; // [RULE_14] [RULE_17]
						pd_warn_q <= 1'b1; // [RULE_16]
						vin_cnt_q <= 32'h0000_0000;
						vin_acc_q <= 34'h0_0000_0000;
						vin_st_q <= SSS_VIN_DWELL;
					end
				end
				SSS_VIN_DWELL: begin
					// accumulate samples across the dwell window
					vin_acc_q <= vin_acc_q + {22'h00_0000, vrms_sample}; // [RULE_18]
					if (vin_cnt_q >= 32'(`SSS_DWELL_CYC) - 32'h1)
						vin_st_q <= SSS_VIN_AVG; // [RULE_19]
					else
						vin_cnt_q <= vin_cnt_q + 32'h1;
				end
				SSS_VIN_AVG: begin
					// mean of the samples over the dwell window; 34 bits hold the full sum
					vrms_avg_q <= 12'(vin_acc_q / 34'(`SSS_DWELL_CYC)); // [RULE_18]
					vin_cnt_q <= 32'h0000_0000;
					vin_acc_q <= 34'h0_0000_0000;
					if (mon.vin_above_min && !vin_loss &&
						12'(vin_acc_q / 34'(`SSS_DWELL_CYC)) != 12'h000) begin
						vin_good_q <= 1'b1; // [RULE_18] [RULE_20]
						pd_warn_q <= 1'b0;
						vin_st_q <= SSS_VIN_GOOD;
					end else
						vin_st_q <= SSS_VIN_DWELL;
				end
				default: vin_st_q <= SSS_VIN_EVAL;
			endcase
		end
	end

	// ----------------------------------------
	// main output sequencing and outputs good
	// ----------------------------------------
	sss_main_t main_st_q;
	logic [31:0] main_cnt_q;
	logic pgood_q;
	logic main_en_q;
	logic main_ok;

	assign main_ok = !req_n_q && !kill_q && !sw_kill && !shut_q && vin_good_q;

	always_ff @(posedge clk) begin
		if (!nrst)
			shut_q <= 1'b0;
		else if (mon.sense_short)
			shut_q <= 1'b1; // [RULE_03]
		else if (ctrl_q[1])
			shut_q <= 1'b0;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			main_st_q <= SSS_MAIN_OFF;
			main_cnt_q <= 32'h0000_0000;
			pgood_q <= 1'b0;
			main_en_q <= 1'b0;
		end else begin
			case (main_st_q)
				SSS_MAIN_OFF: begin
					pgood_q <= 1'b0;
					main_cnt_q <= 32'h0000_0000;
					if (main_ok) begin
						main_en_q <= 1'b1; // [RULE_22]
						main_st_q <= SSS_MAIN_RAMP;
					end
				end
				SSS_MAIN_RAMP: begin
					if (!main_ok) begin
						main_en_q <= 1'b0; // [RULE_01] [RULE_22]
						main_st_q <= SSS_MAIN_HOLD;
					end else if (!mon.rails_in_reg || mon.current_limit)
						main_cnt_q <= 32'h0000_0000; // [RULE_06]
					else if (main_cnt_q >= 32'(`SSS_PGOOD_ON_CYC) - 32'h1) begin
						pgood_q <= 1'b1; // [RULE_04]
						main_st_q <= SSS_MAIN_ON;
					end else
						main_cnt_q <= main_cnt_q + 32'h1;
				end
				SSS_MAIN_ON: begin
					if (!main_ok || !mon.rails_in_reg) begin
						pgood_q <= 1'b0; // [RULE_05] [RULE_24]
						main_en_q <= 1'b0; // [RULE_01] [RULE_22]
						main_cnt_q <= 32'h0000_0000;
						main_st_q <= SSS_MAIN_HOLD;
					end
				end
				SSS_MAIN_HOLD: begin
					pgood_q <= 1'b0;
					main_en_q <= 1'b0;
					if (main_cnt_q >= 32'(`SSS_OFF_MIN_CYC) - 32'h1)
						main_st_q <= SSS_MAIN_OFF; // [RULE_23]
					else
						main_cnt_q <= main_cnt_q + 32'h1;
				end
				default: main_st_q <= SSS_MAIN_OFF;
			endcase
		end
	end

	// ----------------------------------------
	// pins and status
	// ----------------------------------------
	logic alert_w;

	assign alert_w = mon.shut_event || mon.warn_event || shut_q || temp_warn_q ||
		pd_warn_q;

	assign status_w = {23'h00_0000, mon.stby_in_reg, fan_max_q, pd_warn_q, shut_q,
		temp_warn_q, main_en_q, alert_w, vin_good_q, pgood_q};

	always_ff @(posedge clk) begin
		if (!nrst) begin
			outputs_good_o <= 1'b0;
			outputs_good_oe <= 1'b1;
			fault_alert_n_o <= 1'b0;
			fault_alert_n_oe <= 1'b0;
			input_good_o <= 1'b0;
			input_good_oe <= 1'b1;
			presence_n_o <= 1'b0;
			presence_n_oe <= 1'b1;
			main_enable <= 1'b0;
			standby_enable <= 1'b1;
			fan_max_req <= 1'b0;
			power_down_warn <= 1'b0;
			amber_steady <= 1'b0;
		end else begin
			outputs_good_o <= 1'b0;
			outputs_good_oe <= !pgood_q || kill_q; // [RULE_07] [RULE_24]
			fault_alert_n_o <= 1'b0;
			fault_alert_n_oe <= alert_w; // [RULE_08] [RULE_25]
			amber_steady <= alert_w; // [RULE_09]
			input_good_o <= 1'b0;
			input_good_oe <= !vin_good_q; // [RULE_13] [RULE_14]
			presence_n_o <= 1'b0;
			presence_n_oe <= 1'b1; // [RULE_21]
			main_enable <= main_en_q && !kill_q; // [RULE_01]
			standby_enable <= 1'b1; // [RULE_02]
			fan_max_req <= fan_max_q; // [RULE_12]
			power_down_warn <= pd_warn_q; // [RULE_16]
		end
	end

endmodule : sss_status

//--- sss_host.sv
// Purpose: host side model: request drive and pull-ups on open-drain lines
// Assumes: design gives each open-drain pin as output enable, low when enabled
// Notes: a peer supply may share the outputs-good line
`timescale 1ns/10ps

module sss_host (
	// clock
	input wire logic clk,
	// bench controls
	input wire logic want_on,
	input wire logic peer_pgood_oe,
	output logic main_on_request_n,
	// device open-drain enables
	input wire logic outputs_good_oe,
	input wire logic fault_alert_n_oe,
	input wire logic input_good_oe,
	input wire logic presence_n_oe,
	// resolved line levels
	output logic pgood_line,
	output logic alert_line,
	output logic vin_line,
	output logic present_line
);
	// request is low while main output wanted
	always_ff @(posedge clk) begin
		main_on_request_n <= !want_on;
	end

	// ----------------------------------------
	// pull-ups, any enabled driver pulls low
	// ----------------------------------------
	assign pgood_line = !(outputs_good_oe || peer_pgood_oe);
	assign alert_line = !fault_alert_n_oe;
	assign vin_line = !input_good_oe;
	assign present_line = !presence_n_oe;
endmodule : sss_host

//--- sss_status_chk.sv
// Purpose: assertions on the pins of sss_status
// Assumes: nrst synchronous, active low
// Notes: bound to every sss_status instance
`timescale 1ns/10ps

module sss_status_chk (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// pins
	input wire logic pull_out_disconnect_in,
	input wire logic main_on_request_n,
	input wire sss_pkg::sss_mon_t mon,
	input wire logic outputs_good_o,
	input wire logic outputs_good_oe,
	input wire logic fault_alert_n_oe,
	input wire logic input_good_oe,
	input wire logic presence_n_o,
	input wire logic presence_n_oe,
	input wire logic main_enable,
	input wire logic standby_enable,
	input wire logic amber_steady
);
	import sss_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	a_kill_drops_main: assert property (pull_out_disconnect_in [*8] |-> ##4 !main_enable)
		else $error("main output on during pull-out");
	a_request_off: assert property (main_on_request_n [*8] |-> ##4 !main_enable)
		else $error("main output on without request");
	a_sense_short: assert property (mon.sense_short [*4] |-> ##4 !main_enable)
		else $error("main output on after sense short");
	a_stby_on: assert property (standby_enable)
		else $error("standby output disabled");
	a_pgood_unreg: assert property (!mon.rails_in_reg [*3] |-> outputs_good_oe)
		else $error("outputs good released while out of regulation");
	a_pgood_drive: assert property (!outputs_good_o)
		else $error("outputs good driven high");
	a_pgood_with_main: assert property ($fell(main_enable) |-> outputs_good_oe)
		else $error("outputs good kept after main off");
	a_alert_event: assert property ((mon.shut_event || mon.warn_event) |-> ##1 fault_alert_n_oe)
		else $error("alert missing on event");
	a_alert_amber: assert property (amber_steady |-> fault_alert_n_oe)
		else $error("steady amber without alert");
	a_vin_ovp: assert property (mon.vin_ovp [*4] |-> input_good_oe)
		else $error("input good kept on overvoltage");
	a_vin_off: assert property (mon.vin_below_off [*4] |-> input_good_oe)
		else $error("input good kept below turn-off");
	a_present_low: assert property (presence_n_oe && !presence_n_o)
		else $error("presence not pulled low");
endmodule : sss_status_chk

bind sss_status sss_status_chk i_sss_status_chk (.clk, .nrst, .pull_out_disconnect_in,
	.main_on_request_n, .mon, .outputs_good_o, .outputs_good_oe, .fault_alert_n_oe,
	.input_good_oe, .presence_n_o, .presence_n_oe, .main_enable, .standby_enable, .amber_steady);

//--- supply_status_signaling_tb.sv
// Purpose: self-checking bench for sss_status
// Assumes: 40 MHz clock, bready and rready held high
// Notes: long timers are out of reach of a short run
`timescale 1ns/10ps
`include "sss_cfg.svh"

module supply_status_signaling_tb;
	import sss_pkg::*;
	logic clk = 0, nrst = 0, awv = 0, wv = 0, arv = 0, kill = 0, want_on = 0, fan = 0;
	sss_ax_t aw = '0, ar = '0;
	sss_w_t w = '0;
	sss_mon_t mon;
	logic [11:0] vrms = '0;
	logic awr, wr, bv, arr, rv, req_n, pg_oe, al_oe, vin_oe, pr_oe, al_o, vin_o;
	logic main_en, stby_en, fan_req, pd_warn, amber;
	logic pgood_line, alert_line, vin_line, present_line;
	logic [31:0] rd, d;
	sss_resp_t br, rr;
	int errors = 0, compares = 0, cyc = 0;
	integer seed = 32'ha8d1;

	always #12.5 clk = ~clk;

	sss_status i_sss_status (.clk(clk), .nrst(nrst), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_aw(aw), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_w(w), .s_axi_bvalid(bv),
		.s_axi_bready(1'b1), .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_ar(ar), .s_axi_rvalid(rv), .s_axi_rready(1'b1), .s_axi_rdata(rd), .s_axi_rresp(rr),
		.pull_out_disconnect_in(kill), .main_on_request_n(req_n), .outputs_good_o(),
		.outputs_good_oe(pg_oe), .fault_alert_n_o(al_o), .fault_alert_n_oe(al_oe),
		.input_good_o(vin_o),
		.input_good_oe(vin_oe), .presence_n_o(), .presence_n_oe(pr_oe), .mon(mon),
		.vrms_sample(vrms), .fan_at_max(fan), .main_enable(main_en), .standby_enable(stby_en),
		.fan_max_req(fan_req), .power_down_warn(pd_warn), .amber_steady(amber));

	sss_host i_sss_host (.clk(clk), .want_on(want_on), .peer_pgood_oe(1'b0),
		.main_on_request_n(req_n), .outputs_good_oe(pg_oe), .fault_alert_n_oe(al_oe),
		.input_good_oe(vin_oe), .presence_n_oe(pr_oe), .pgood_line(pgood_line),
		.alert_line(alert_line), .vin_line(vin_line), .present_line(present_line));

	// ----------------------------------------
	// checking and expectations
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	function automatic logic exp_alert_line(input logic [1:0] ev);
		return !(ev[0] | ev[1]);
	endfunction : exp_alert_line

	function automatic logic exp_warn(input logic [7:0] t);
		return t >= 8'(`SSS_INLET_WARN_C);
	endfunction : exp_warn

	task report_and_stop;
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : report_and_stop

	always @(posedge clk) begin
		cyc++;
		if (cyc == 99000) begin
			errors++;
			report_and_stop();
		end
	end

	// ----------------------------------------
	// register bus master
	// ----------------------------------------
	task automatic axw(input logic [11:0] a, input logic [31:0] dat, input sss_resp_t er);
		logic ad, wd;
		ad = 0;
		wd = 0;
		@(posedge clk);
		awv <= 1;
		aw <= '{a, 3'h0};
		wv <= 1;
		w <= '{dat, 4'hf};
		while (!(ad && wd)) begin
			@(posedge clk);
			if (awv && awr) begin
				ad = 1;
				awv <= 0;
			end
			if (wv && wr) begin
				wd = 1;
				wv <= 0;
			end
		end
		do @(posedge clk); while (!bv);
		chk(32'(br), 32'(er));
	endtask : axw

	task automatic axr(input logic [11:0] a, input sss_resp_t er, output logic [31:0] dat);
		@(posedge clk);
		arv <= 1;
		ar <= '{a, 3'h0};
		do @(posedge clk); while (!arr);
		arv <= 0;
		do @(posedge clk); while (!rv);
		dat = rd;
		chk(32'(rr), 32'(er));
	endtask : axr

	task automatic do_reset;
		nrst <= 0;
		repeat (4) @(posedge clk);
		nrst <= 1;
		@(posedge clk);
	endtask : do_reset

	task automatic wait_main(input logic v);
		int n;
		n = 0;
		while (main_en !== v && n < 40) begin
			@(posedge clk);
			n++;
		end
	endtask : wait_main

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		mon <= '{vin_above_min: 1'b1, stby_in_reg: 1'b1, default: 1'b0};
		do_reset();
		chk(main_en, 0);
		chk(al_o, 0);
		chk(vin_o, 0);
		chk(stby_en, 1);
		chk(present_line, 0);
		chk(pgood_line, 0);
		chk(alert_line, 1);
		axr(`SSS_REG_CTRL, SSS_RESP_OKAY, d);
		chk(d, `SSS_CTRL_RST);
		axw(12'h010, 32'hffff_ffff, SSS_RESP_SLVERR);
		axr(12'h010, SSS_RESP_SLVERR, d);
		chk(d, 32'h0);
		// inlet warning waits for the fan
		axw(`SSS_REG_TEMP, 32'h3c, SSS_RESP_OKAY);
		repeat (4) @(posedge clk);
		chk(fan_req, 1);
		chk(alert_line, 1);
		fan <= 1;
		repeat (4) @(posedge clk);
		axr(`SSS_REG_STATUS, SSS_RESP_OKAY, d);
		chk(d[`SSS_ST_WARN_TEMP], exp_warn(8'h3c));
		chk(alert_line, 0);
		axw(`SSS_REG_TEMP, 32'h3b, SSS_RESP_OKAY);
		repeat (4) @(posedge clk);
		axr(`SSS_REG_STATUS, SSS_RESP_OKAY, d);
		chk(d[`SSS_ST_WARN_TEMP], exp_warn(8'h3b));
		chk(alert_line, 1);
		fan <= 0;
		// main output on, glitch ignored, sense short
		want_on <= 1;
		wait_main(1);
		chk(main_en, 1);
		kill <= 1;
		repeat (2) @(posedge clk);
		kill <= 0;
		repeat (12) @(posedge clk);
		chk(main_en, 1);
		mon.sense_short <= 1;
		repeat (4) @(posedge clk);
		mon.sense_short <= 0;
		wait_main(0);
		chk(main_en, 0);
		axw(`SSS_REG_CTRL, 32'h2, SSS_RESP_OKAY);
		axr(`SSS_REG_STATUS, SSS_RESP_OKAY, d);
		chk(d[`SSS_ST_SHUT], 0);
		// restart is held off for a second; reset brings main back
		do_reset();
		wait_main(1);
		chk(main_en, 1);
		kill <= 1;
		repeat (12) @(posedge clk);
		chk(main_en, 0);
		chk(stby_en, 1);
		chk(pgood_line, 0);
		kill <= 0;
		want_on <= 0;
		// random event mix
		for (int i = 0; i < 24; i++) begin
			d = $random(seed);
			mon.shut_event <= d[0];
			mon.warn_event <= d[1];
			vrms <= d[15:4];
			repeat (3) @(posedge clk);
			chk(alert_line, exp_alert_line(d[1:0]));
			chk(amber, !exp_alert_line(d[1:0]));
		end
		mon.shut_event <= 0;
		mon.warn_event <= 0;
		// input faults
		mon.vin_ovp <= 1;
		repeat (4) @(posedge clk);
		chk(vin_line, 0);
		chk(pd_warn, 1);
		mon.vin_ovp <= 0;
		// dwell keeps input good low; reset gives a fresh good state
		do_reset();
		repeat (4) @(posedge clk);
		chk(vin_line, 1);
		chk(alert_line, 1);
		mon.vin_below_off <= 1;
		for (int n = 0; n < `SSS_ALERT_MS * 40000 && alert_line !== 1'b0; n++) @(posedge clk);
		chk(alert_line, 0);
		chk(vin_line, 0);
		chk(pd_warn, 1);
		report_and_stop();
	end
endmodule : supply_status_signaling_tb
